// [common/direction_pkg.sv]
package direction_pkg;
  // ===========================================================
  // register addresses
  localparam logic [7:0] ADDR_CONFIG = 8'h38;
  localparam logic [7:0] ADDR_SOURCE = 8'h39;
  localparam logic [7:0] ADDR_ACK = 8'h3a;
  localparam logic [7:0] ADDR_INNER_LOW = 8'h3c;
  localparam logic [7:0] ADDR_INNER_HIGH = 8'h3d;
  localparam logic [7:0] ADDR_OUTER_LOW = 8'h3e;
  localparam logic [7:0] ADDR_OUTER_HIGH = 8'h3f;
  // ===========================================================
  // config fields
  localparam int CFG_IRQ_ENABLE = 7;
  localparam int CFG_LATCH = 6;
  localparam int CFG_Z_HIGH = 5;
  localparam int CFG_Z_LOW = 4;
  localparam int CFG_Y_HIGH = 3;
  localparam int CFG_Y_LOW = 2;
  localparam int CFG_X_HIGH = 1;
  localparam int CFG_X_LOW = 0;
  // source fields: bit 7 reads zero
  localparam int SRC_ACTIVE = 6;
  localparam int SRC_FLAGS_MSB = 5;
  localparam int CFG_ENABLE_MSB = 5;
  // per-axis flag pair codes, {high, low}
  localparam logic [1:0] FLAGS_NONE = 2'h0;
  localparam logic [1:0] FLAGS_LOW = 2'h1;
  localparam logic [1:0] FLAGS_HIGH = 2'h2;
  localparam logic [5:0] DIR_ZERO = 6'h00;
  // axis flag pair at bit 2*axis (low) and 2*axis+1 (high), axis 0=x
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam int AXES = 3;
endpackage

// [core/accel_direction_detector.sv]
`timescale 1ns/1ps
// How it works
// R1: interrupt output driven only when enable set
// R2: latch holds request until acknowledge read
// R3: per-axis high enables gate interrupt requests
// R4: per-axis low enables gate interrupt requests
// R5: event flag set on direction change
// R6: high flag above outer positive threshold
// R7: low flag beyond outer negative threshold
// R8: flags clear below inner threshold magnitude
// R9: acknowledge read releases the latch and clears the latched event bit
// R10: outer threshold sixteen bits, low byte first
// R11: inner threshold sixteen bits, same compare
// R12: unlatched source follows every new sample
module accel_direction_detector
  import direction_pkg::*;
(
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic sample_valid_i,
  input wire logic [15:0] x_sample_i,
  input wire logic [15:0] y_sample_i,
  input wire logic [15:0] z_sample_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic direction_irq_o
);

  // ===========================================================
  // helpers
  // 8000h has no positive twin; its magnitude reads as 8000h unsigned
  function automatic logic [15:0] magnitude(input logic [15:0] s);
    magnitude = s[15] ? 16'(-s) : s;
  endfunction

  // ===========================================================
  // configuration and thresholds
  logic [7:0] config_reg, config_next;
  logic [15:0] inner_reg, inner_next;
  logic [15:0] outer_reg, outer_next;

  always_comb begin
    config_next = config_reg;
    inner_next = inner_reg;
    outer_next = outer_reg;
    if (reg_write_i) begin
      unique case (reg_addr_i)
        ADDR_CONFIG: config_next = reg_wdata_i;
        ADDR_INNER_LOW: inner_next[7:0] = reg_wdata_i; // see R11
        ADDR_INNER_HIGH: inner_next[15:8] = reg_wdata_i; // see R11
        ADDR_OUTER_LOW: outer_next[7:0] = reg_wdata_i; // see R10
        ADDR_OUTER_HIGH: outer_next[15:8] = reg_wdata_i; // see R10
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      config_reg <= BYTE_ZERO; // see R1
      inner_reg <= WORD_ZERO;
      outer_reg <= WORD_ZERO;
    end else begin
      config_reg <= config_next;
      inner_reg <= inner_next;
      outer_reg <= outer_next;
    end
  end

  // ===========================================================
  // per-axis hysteresis direction state
  logic [15:0] sample [AXES];
  logic [5:0] dir_reg, dir_next;
  logic [5:0] enables;
  assign sample[0] = x_sample_i;
  assign sample[1] = y_sample_i;
  assign sample[2] = z_sample_i;
  assign enables = config_reg[CFG_ENABLE_MSB:0]; // see R3, R4

  always_comb begin
    dir_next = dir_reg;
    if (sample_valid_i) begin
      for (int a = 0; a < AXES; a++) begin
        // flag held between thresholds; compares are on unsigned magnitudes
        if (magnitude(sample[a]) < inner_reg) begin
          dir_next[2*a +: 2] = FLAGS_NONE; // see R8
        end else if (!sample[a][15] && sample[a] > outer_reg) begin
          dir_next[2*a +: 2] = FLAGS_HIGH; // see R6
        end else if (sample[a][15] && magnitude(sample[a]) > outer_reg) begin
          dir_next[2*a +: 2] = FLAGS_LOW; // see R7
        end
      end
    end
  end

  // ===========================================================
  // source register, latch and interrupt
  // in latched mode ack clears the event bit and releases the hold; the flags refresh on the next sample
  logic [7:0] source_reg, source_next;
  logic held_reg, held_next;
  logic irq_reg, irq_next;
  logic [7:0] rdata_reg, rdata_next;
  logic changed;
  logic ack_read;

  assign changed = sample_valid_i && ((dir_next & enables) != (dir_reg & enables));
  assign ack_read = reg_read_i && reg_addr_i == ADDR_ACK;

  always_comb begin
    source_next = source_reg;
    held_next = held_reg;
    if (!config_reg[CFG_LATCH]) begin
      held_next = 1'b0;
      if (sample_valid_i) begin
        source_next = {1'b0, changed, dir_next}; // see R5, R12
      end
    end else begin
      // new event wins over a same-cycle acknowledge
      if (ack_read) begin
        held_next = 1'b0; // see R9
      end
      if (sample_valid_i && (!held_reg || ack_read)) begin
        source_next = {1'b0, changed, dir_next}; // see R2, R9
        held_next = changed; // see R2
      end else if (ack_read) begin
        source_next[SRC_ACTIVE] = 1'b0;
      end
    end
    irq_next = config_reg[CFG_IRQ_ENABLE] && source_next[SRC_ACTIVE]; // see R1
  end

  always_comb begin
    rdata_next = rdata_reg;
    if (reg_read_i) begin
      unique case (reg_addr_i)
        ADDR_CONFIG: rdata_next = config_reg;
        ADDR_SOURCE: rdata_next = source_reg;
        ADDR_INNER_LOW: rdata_next = inner_reg[7:0];
        ADDR_INNER_HIGH: rdata_next = inner_reg[15:8];
        ADDR_OUTER_LOW: rdata_next = outer_reg[7:0];
        ADDR_OUTER_HIGH: rdata_next = outer_reg[15:8];
        // acknowledge and holes read zero; the value carries no meaning
        default: rdata_next = BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      dir_reg <= DIR_ZERO;
      source_reg <= BYTE_ZERO;
      held_reg <= 1'b0;
      irq_reg <= 1'b0;
      rdata_reg <= BYTE_ZERO;
    end else begin
      dir_reg <= dir_next;
      source_reg <= source_next;
      held_reg <= held_next;
      irq_reg <= irq_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign direction_irq_o = irq_reg;

  // ===========================================================
  // checks
  AST_IRQ_GATED: assert property (@(posedge clock_i) disable iff (!resetn_i) // see R1
    direction_irq_o |-> $past(config_reg[CFG_IRQ_ENABLE]))
    else $error("irq without enable");
  AST_LATCH_HOLDS: assert property (@(posedge clock_i) disable iff (!resetn_i) // see R2
    held_reg && config_reg[CFG_LATCH] && !ack_read |=> $stable(source_reg))
    else $error("latched source changed");
  AST_ACK_RELEASES: assert property (@(posedge clock_i) disable iff (!resetn_i) // see R9
    config_reg[CFG_LATCH] && ack_read && !sample_valid_i |=> !held_reg)
    else $error("ack did not release");
  AST_HIGH_FLAG: assert property (@(posedge clock_i) disable iff (!resetn_i) // see R6
    sample_valid_i && !x_sample_i[15] && x_sample_i > outer_reg
    && x_sample_i >= inner_reg |=> dir_reg[1:0] == FLAGS_HIGH)
    else $error("x high flag missing");
  AST_LOW_FLAG: assert property (@(posedge clock_i) disable iff (!resetn_i) // see R7
    sample_valid_i && y_sample_i[15] && magnitude(y_sample_i) > outer_reg
    && magnitude(y_sample_i) >= inner_reg |=> dir_reg[3:2] == FLAGS_LOW)
    else $error("y low flag missing");
  AST_INNER_CLEARS: assert property (@(posedge clock_i) disable iff (!resetn_i) // see R8
    sample_valid_i && magnitude(z_sample_i) < inner_reg |=> dir_reg[5:4] == FLAGS_NONE)
    else $error("z flags not cleared");
  AST_EVENT_ACTIVE: assert property (@(posedge clock_i) disable iff (!resetn_i) // see R5
    !config_reg[CFG_LATCH] && sample_valid_i |=> source_reg[SRC_ACTIVE] == $past(changed))
    else $error("event flag mismatch");
  AST_UNLATCHED_FOLLOWS: assert property (@(posedge clock_i) disable iff (!resetn_i) // see R12
    !config_reg[CFG_LATCH] && sample_valid_i |=> source_reg[SRC_FLAGS_MSB:0] == dir_reg)
    else $error("source stale");
  AST_OUTER_BYTES: assert property (@(posedge clock_i) disable iff (!resetn_i) // see R10
    reg_write_i && reg_addr_i == ADDR_OUTER_HIGH |=> outer_reg[15:8] == $past(reg_wdata_i))
    else $error("outer high byte");
  AST_INNER_BYTES: assert property (@(posedge clock_i) disable iff (!resetn_i) // see R11
    reg_write_i && reg_addr_i == ADDR_INNER_LOW |=> inner_reg[7:0] == $past(reg_wdata_i))
    else $error("inner low byte");
  AST_ENABLE_MASK: assert property (@(posedge clock_i) disable iff (!resetn_i) // see R3, R4
    sample_valid_i && !held_reg && enables == DIR_ZERO |=> !source_reg[SRC_ACTIVE])
    else $error("event with all enables off");
  AST_OUTER_LOW_BYTE: assert property (@(posedge clock_i) disable iff (!resetn_i) // see R10
    reg_write_i && reg_addr_i == ADDR_OUTER_LOW |=> outer_reg[7:0] == $past(reg_wdata_i))
    else $error("outer low byte");
  AST_INNER_HIGH_BYTE: assert property (@(posedge clock_i) disable iff (!resetn_i) // see R11
    reg_write_i && reg_addr_i == ADDR_INNER_HIGH |=> inner_reg[15:8] == $past(reg_wdata_i))
    else $error("inner high byte");
  AST_ACK_CLEARS_EVENT: assert property (@(posedge clock_i) disable iff (!resetn_i) // see R9
    config_reg[CFG_LATCH] && ack_read && !sample_valid_i |=> !source_reg[SRC_ACTIVE])
    else $error("ack left event set");
  AST_NO_HOLD_UNLATCHED: assert property (@(posedge clock_i) disable iff (!resetn_i) // see R2
    !config_reg[CFG_LATCH] |=> !held_reg)
    else $error("held without latch");
  AST_IRQ_STANDS: assert property (@(posedge clock_i) disable iff (!resetn_i) // see R1
    config_reg[CFG_IRQ_ENABLE] && source_reg[SRC_ACTIVE] && !sample_valid_i && !ack_read
    && !reg_write_i |=> direction_irq_o)
    else $error("irq dropped while event set");

endmodule

// [sim/host_model.sv]
`timescale 1ns/1ps
// ==========================================================
// host side of the register port
module host_model (
  input wire logic clock_i,
  input wire logic [7:0] rdata_i,
  output logic write_o,
  output logic read_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  initial begin
    write_o = 1'b0;
    read_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  // released lines show the inverse, never a stale copy
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    write_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clock_i);
    write_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_i);
    read_o <= 1'b1;
    addr_o <= a;
    @(posedge clock_i);
    read_o <= 1'b0;
    addr_o <= ~a;
    #1 d = rdata_i;
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 8'h01, v[15:8]);
  endtask
endmodule

// [sim/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import direction_pkg::*;
  localparam logic [15:0] INNER = 16'h0100;
  localparam logic [15:0] OUTER = 16'h0400;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic sample_valid_i = 1'b0;
  logic [47:0] smp = '0;
  logic wr_s, rd_s, irq;
  logic [7:0] addr, wdata, rdata, d;
  logic [5:0] flags = '0;
  logic [7:0] cfgs [5] = '{8'hbf, 8'h3f, 8'h8c, 8'hb0, 8'h80};
  logic [63:0] regmap = '0;
  logic [7:0] regs [8] = '{8'h38, 8'h39, 8'h3a, 8'h3b, 8'h3c, 8'h3d, 8'h3e, 8'h3f};
  int mismatches = 0;
  int n_checks = 0;
  always #2 clock_i = ~clock_i;
  accel_direction_detector i_dut (.clock_i(clock_i), .resetn_i(resetn_i),
    .sample_valid_i(sample_valid_i), .x_sample_i(smp[15:0]), .y_sample_i(smp[31:16]),
    .z_sample_i(smp[47:32]), .reg_write_i(wr_s), .reg_read_i(rd_s), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .direction_irq_o(irq));
  host_model i_host (.clock_i(clock_i), .rdata_i(rdata), .write_o(wr_s), .read_o(rd_s),
    .addr_o(addr), .wdata_o(wdata));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [5:0] nflags(input logic [5:0] f, input logic [47:0] s);
    logic [15:0] v;
    logic [15:0] m;
    for (int a = 0; a < AXES; a++) begin
      v = s[16*a +: 16];
      m = v[15] ? -v : v;
      if (m < INNER) f[2*a +: 2] = 2'b00;
      else if (m > OUTER) f[2*a +: 2] = v[15] ? 2'b01 : 2'b10;
    end
    return f;
  endfunction
  function automatic logic [15:0] rnd();
    logic [15:0] v;
    v = 16'($urandom_range(0, 16'h0600));
    return $urandom_range(0, 1) ? -v : v;
  endfunction
  // ==========================================================
  // one sample, then irq and source compared
  task automatic sample(input logic [47:0] s, input logic [7:0] cfg, input bit chk);
    logic [5:0] nf;
    logic ev;
    nf = nflags(flags, s);
    ev = (nf & cfg[5:0]) != (flags & cfg[5:0]);
    flags = nf;
    @(posedge clock_i);
    sample_valid_i <= 1'b1;
    smp <= s;
    @(posedge clock_i);
    sample_valid_i <= 1'b0;
    #1;
    if (chk) begin
      check({7'h00, irq}, {7'h00, cfg[7] & ev});
      i_host.rd(ADDR_SOURCE, d);
      if (cfg[5:0] == 6'h3f) check(d, {1'b0, ev, nf});
      else check(d & 8'hc0, {1'b0, ev, 6'h00});
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clock_i);
    mismatches++;
    finish_test();
  end
  initial begin
    d = 8'($urandom(79));
    repeat (20) @(posedge clock_i);
    resetn_i <= 1'b1;
    foreach (regs[i]) begin
      i_host.rd(regs[i], d);
      check(d, 8'h00);
    end
    i_host.wr16(ADDR_INNER_LOW, INNER);
    i_host.wr16(ADDR_OUTER_LOW, OUTER);
    i_host.wr(ADDR_SOURCE, 8'hff);
    i_host.wr(ADDR_CONFIG, 8'h5a);
    regmap = {8'h5a, 8'h00, 8'h00, 8'h00, INNER[7:0], INNER[15:8], OUTER[7:0], OUTER[15:8]};
    foreach (regs[i]) begin
      i_host.rd(regs[i], d);
      check(d, regmap[8 * (7 - i) +: 8]);
    end
    foreach (cfgs[c]) begin
      i_host.wr(ADDR_CONFIG, cfgs[c]);
      sample('0, cfgs[c], 1'b0);
      repeat (12) sample({rnd(), rnd(), rnd()}, cfgs[c], 1'b1);
    end
    // latched: a second change must not disturb the held source
    // settle to zero flags unlatched, so nothing is held before the latch is set
    i_host.wr(ADDR_CONFIG, 8'hbf);
    sample('0, 8'hbf, 1'b0);
    i_host.wr(ADDR_CONFIG, 8'hff);
    sample({32'h0, 16'h0500}, 8'hff, 1'b1);
    sample({32'h0, 16'hfb00}, 8'hff, 1'b0);
    i_host.rd(ADDR_SOURCE, d);
    check(d, 8'h42);
    check({7'h00, irq}, 8'h01);
    i_host.rd(ADDR_ACK, d);
    i_host.rd(ADDR_SOURCE, d);
    check(d & 8'h40, 8'h00);
    check({7'h00, irq}, 8'h00);
    // mid-run reset returns every register to zero
    @(posedge clock_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    resetn_i <= 1'b1;
    foreach (regs[i]) begin
      i_host.rd(regs[i], d);
      check(d, 8'h00);
    end
    check({7'h00, irq}, 8'h00);
    finish_test();
  end
endmodule
